// *** dv/tb.sv ***
`timescale 1ns/100ps
// ----------
// bench top
// ----------
module tb;
  import vfiu_pkg::*;
  logic ref_clk, sys_rst, clk_en, reg_wr, ret_instr, en_instr, dis_instr;
  logic instr_end, stall, irq_pulse, ack, stk_push, vec_rd, pc_load;
  logic flags_load, busy, irq_seen, irq_clr;
  logic [9:0] src_req, src_en, sw_clr, r;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, stk_data, vec_addr;
  logic [7:0] cpu_flags, flags_value, d, f0;
  logic [15:0] cpu_pc, pc_value, p0, ip;
  logic [2:0] ack_level;
  int fails, tests_run, seed, i, n;
  vfiu_top vfiu_top_inst (.*);
  vfiu_core_model vfiu_core_model_inst (.*);
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    irq_seen <= irq_clr ? 1'b0 : (irq_seen | (irq_pulse === 1'b1));
  end
  function automatic logic [7:0] lvl_of(input logic [9:0] p);
    lvl_of = {p[9:5], p[4] | p[3], p[2], p[1] | p[0]};
  endfunction
  function automatic int src_of(input int l);
    src_of = (l == 0) ? 0 : (l < 3) ? l + 1 : l + 2;
  endfunction
  function automatic logic [15:0] ent_exp(input int k, input logic [7:0] v);
    case (k)
      0: ent_exp = {8'h04, p0[7:0]};
      1: ent_exp = {8'h04, p0[15:8]};
      2: ent_exp = {8'h04, f0};
      3: ent_exp = {8'h02, v};
      4: ent_exp = {8'h02, v + 8'h01};
      default: ent_exp = 16'h0100;
    endcase
  endfunction
  task automatic finish_test;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, g);
    tests_run++;
    if (g !== e) begin
      $display("MISMATCH %s exp %h got %h", nm, e, g);
      fails++;
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge ref_clk);
  endtask
  task automatic wr(input logic [7:0] a, v);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    cyc(1);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    reg_addr = a;
    cyc(2);
    v = reg_rdata;
  endtask
  task automatic pulse_src(input logic [9:0] q, c);
    src_req = q;
    sw_clr = c;
    cyc(1);
    src_req = 10'h0;
    sw_clr = 10'h0;
  endtask
  task automatic ret_pulse;
    stall = 1'b1;
    ret_instr = 1'b1;
    cyc(1);
    ret_instr = 1'b0;
  endtask
  // w: 0 ack, 1 pc_load, 2 busy low
  task automatic wait_on(input int w);
    n = 0;
    while (((w == 0) ? ack : (w == 1) ? pc_load : !busy) !== 1'b1) begin
      cyc(1);
      n++;
      if (n > 40) begin
        chk("timeout", 16'h0, 16'h1);
        finish_test();
      end
    end
  endtask
  task automatic quiet(input int k);
    repeat (k) begin
      cyc(1);
      if (ack === 1'b1) chk("early ack", 16'h0, 16'h1);
    end
  endtask
  task automatic vent(input logic [2:0] lv, input logic [7:0] v);
    p0 = cpu_pc;
    f0 = cpu_flags;
    chk("level", {13'h0, lv}, {13'h0, ack_level});
    for (i = 0; i < 6; i++) begin
      cyc(1);
      chk("entry", ent_exp(i, v), {5'h0, stk_push, vec_rd, pc_load,
        (i < 3) ? stk_data : (i < 5) ? vec_addr : 8'h0});
    end
  endtask
  initial begin
    seed = 19;
    {clk_en, reg_wr, ret_instr, en_instr, dis_instr, stall} = 6'b100001;
    {src_req, src_en, sw_clr} = 30'h0;
    {reg_addr, reg_wdata} = 16'h0;
    irq_clr = 1'b1;
    sys_rst = 1'b1;
    cyc(10);
    sys_rst = 1'b0;
    cyc(1);
    rd(VFIU_ADDR_LVL_REQ, d);
    chk("req reset", 16'h0, {8'h0, d});
    rd(VFIU_ADDR_MODE, d);
    chk("mode reset", 16'h0, {13'h0, d[7], d[1:0]});
    wr(VFIU_ADDR_MASK, 8'hff);
    dis_instr = 1'b1;
    cyc(1);
    dis_instr = 1'b0;
    stall = 1'b0;
    for (int k = 0; k < 16; k++) begin
      src_en = 10'($random(seed));
      r = 10'($random(seed)) & 10'h3f0;
      pulse_src(r, 10'h0);
      wr(VFIU_ADDR_LVL_REQ, 8'hff);
      rd(VFIU_ADDR_LVL_REQ, d);
      chk("req", lvl_of(r & src_en), d);
      rd(VFIU_ADDR_LVL_REQ, d);
      chk("req again", lvl_of(r & src_en), d);
      chk("no service", 16'h0, {15'h0, busy});
      pulse_src(10'h0, r);
      rd(VFIU_ADDR_LVL_REQ, d);
      chk("req clear", 16'h0, {8'h0, d});
    end
    $display("random request test done");
    src_en = 10'h3ff;
    stall = 1'b1;
    irq_clr = 1'b1;
    cyc(1);
    irq_clr = 1'b0;
    pulse_src(10'h203, 10'h0);
    en_instr = 1'b1;
    cyc(1);
    en_instr = 1'b0;
    quiet(6);
    chk("irq pulse", 16'h1, {15'h0, irq_seen});
    stall = 1'b0;
    wait_on(0);
    vent(3'h0, VFIU_VEC_BASE);
    wait_on(2);
    rd(VFIU_ADDR_MODE, d);
    chk("gie off", 16'h0, {15'h0, d[0]});
    rd(VFIU_ADDR_LVL_REQ, d);
    chk("req left", 16'h81, {8'h0, d});
    quiet(4);
    ret_pulse();
    rd(VFIU_ADDR_MODE, d);
    chk("gie on", 16'h1, {15'h0, d[0]});
    stall = 1'b0;
    wait_on(0);
    vent(3'h0, VFIU_VEC_BASE + 8'h02);
    wait_on(2);
    rd(VFIU_ADDR_LVL_REQ, d);
    chk("hw cleared", 16'h80, {8'h0, d});
    $display("vectored entry test done");
    wr(VFIU_ADDR_MASK, 8'h7f);
    ret_pulse();
    stall = 1'b0;
    quiet(8);
    src_en = 10'h1ff;
    wr(VFIU_ADDR_MASK, 8'hff);
    quiet(4);
    rd(VFIU_ADDR_LVL_REQ, d);
    chk("src off", 16'h0, {8'h0, d});
    src_en = 10'h3ff;
    wait_on(0);
    chk("level 7", 16'h7, {13'h0, ack_level});
    wait_on(2);
    pulse_src(10'h0, 10'h200);
    ret_pulse();
    $display("mask test done");
    for (int l = 0; l < 8; l++) begin
      ip = 16'($random(seed));
      wr(VFIU_ADDR_PTR_HI, ip[15:8]);
      wr(VFIU_ADDR_PTR_LO, ip[7:0]);
      wr(VFIU_ADDR_MODE, {3'h0, l[2:0], 2'b00});
      wr(VFIU_ADDR_MODE, {3'h0, l[2:0], 2'b11});
      pulse_src(10'h1 << src_of(l), 10'h0);
      stall = 1'b0;
      wait_on(0);
      p0 = cpu_pc;
      f0 = cpu_flags;
      chk("fast level", {13'h0, l[2:0]}, {13'h0, ack_level});
      cyc(1);
      chk("fast load", 16'h3, {14'h0, pc_load, flags_load});
      chk("fast pc", ip, pc_value);
      chk("fast flags", {8'h0, f0 | 8'h02}, {8'h0, flags_value});
      wait_on(2);
      pulse_src(10'h0, 10'h3f0);
      ret_pulse();
      wait_on(1);
      chk("ret pc", p0, pc_value);
      chk("ret flags", {8'h0, f0 & 8'hfd}, {8'h0, flags_value});
      rd(VFIU_ADDR_PTR_HI, d);
      chk("ptr hi", {8'h0, ip[15:8]}, {8'h0, d});
      rd(VFIU_ADDR_PTR_LO, d);
      chk("ptr lo", {8'h0, ip[7:0]}, {8'h0, d});
    end
    $display("fast entry test done");
    finish_test();
  end
endmodule // tb

// *** dv/vfiu_core_model.sv ***
`timescale 1ns/100ps
// ----------
// core model: instruction ends, pc and flags
// ----------
module vfiu_core_model #(
  parameter logic [15:0] PC0 = 16'h4c2e,
  parameter logic [7:0] FLAGS0 = 8'ha5
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic stall,
  input wire logic busy,
  input wire logic pc_load,
  input wire logic [15:0] pc_value,
  input wire logic flags_load,
  input wire logic [7:0] flags_value,
  output logic instr_end,
  output logic [15:0] cpu_pc,
  output logic [7:0] cpu_flags
);
  // no instruction boundary while stalled or during entry
  assign instr_end = !stall && !busy;
  always @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      cpu_pc <= PC0;
      cpu_flags <= FLAGS0;
    end else begin
      if (pc_load) cpu_pc <= pc_value;
      if (flags_load) cpu_flags <= flags_value;
    end
  end
endmodule // vfiu_core_model

// *** hdl/vfiu_pkg.sv ***
package vfiu_pkg;
  // ----------------------------------------
  // register addresses
  // ----------------------------------------
  localparam logic [7:0] VFIU_ADDR_PTR_HI = 8'hda;
  localparam logic [7:0] VFIU_ADDR_PTR_LO = 8'hdb;
  localparam logic [7:0] VFIU_ADDR_LVL_REQ = 8'hdc;
  localparam logic [7:0] VFIU_ADDR_MASK = 8'hdd;
  localparam logic [7:0] VFIU_ADDR_MODE = 8'hde;
  localparam logic [7:0] VFIU_ADDR_PRIO = 8'hff;
  // ----------------------------------------
  // field positions and reset values
  // ----------------------------------------
  localparam int VFIU_MODE_GIE = 0;
  localparam int VFIU_MODE_FEN = 1;
  localparam int VFIU_MODE_FLV_LO = 2;
  localparam int VFIU_MODE_B7 = 7;
  localparam int VFIU_FLAG_FS = 1;
  localparam logic [7:0] VFIU_LVL_REQ_RST = 8'h00;
  localparam logic [7:0] VFIU_MODE_RST = 8'h00;
  localparam logic [7:0] VFIU_MASK_RST = 8'h00;
  // ----------------------------------------
  // sources and vectors
  // ----------------------------------------
  localparam int VFIU_NSRC = 10;
  localparam int VFIU_NLVL = 8;
  localparam logic [VFIU_NSRC-1:0] VFIU_HW_CLR = 10'h00f;
  localparam logic [7:0] VFIU_VEC_BASE = 8'he0;
  // ----------------------------------------
  // entry timing in cycles
  // ----------------------------------------
  localparam logic [3:0] VFIU_VEC_CYC = 4'ha;
  localparam logic [3:0] VFIU_FAST_CYC = 4'h6;
endpackage

// *** hdl/vfiu_src_pend.sv ***
`timescale 1ns/100ps
module vfiu_src_pend
  import vfiu_pkg::*;
#(
  parameter int NSRC = VFIU_NSRC
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [NSRC-1:0] src_req,
  input wire logic [NSRC-1:0] sw_clr,
  input wire logic [NSRC-1:0] ack_clr,
  output logic [NSRC-1:0] pend
);
  // ----------------------------------------
  // pending bits, set beats clear
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pend <= '0;
    end else if (clk_en) begin
      pend <= src_req | (pend & ~((ack_clr & VFIU_HW_CLR) |
              (sw_clr & ~VFIU_HW_CLR)));
    end
  end
endmodule // vfiu_src_pend

// *** hdl/vfiu_top.sv ***
`timescale 1ns/100ps
// What this block does
// - level request bit n is 1 while level n has a request outstanding.
// - level request register is read-only, readable anytime without side effect.
// - reset clears the level request register to zero.
// - requests latch and show even while global enable is off.
// - hardware-cleared pending bits set on request, clear on acknowledge.
// - sources at vectors e0,e2,e4,e6 are hardware-cleared; others software.
// - software clears its pending bit by pulsing its sw_clr bit high before return.
// - service needs global enable, level mask, top priority, source enable.
// - acknowledge only at end of the current instruction.
// - entry clears global enable, saves pc and flags, then vectors.
// - return sets global enable; only a fast return also restores pc and flags.
// - push pc low, pc high, flags; fetch vector high, low; branch.
// - vectors are even addresses within rom 00..ff.
// - nested higher request taken once software re-enables global enable.
// - instruction pointer is a 16-bit pair at da (high), db (low).
// - fast entry about six cycles, vectored entry about ten.
// - mode bits 4..2 pick fast level, bit 1 enables fast mode.
// - fast entry swaps pointer and pc, shadows flags, sets fast status.
// - fast return swaps back, restores flags, clears fast status.
// - any level 0..7 can be chosen for fast service.
// - fast service reliable only with one source on the vector.
// - reset clears mode bits 7, 1 and 0.
// - mask bit 0 blocks its level, 1 allows it.
// - within a level the lower vector address is served first.
module vfiu_top
  import vfiu_pkg::*;
#(
  parameter int NSRC = VFIU_NSRC
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [NSRC-1:0] src_req,
  input wire logic [NSRC-1:0] src_en,
  input wire logic [NSRC-1:0] sw_clr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic instr_end,
  input wire logic ret_instr,
  input wire logic en_instr,
  input wire logic dis_instr,
  input wire logic [15:0] cpu_pc,
  input wire logic [7:0] cpu_flags,
  output logic irq_pulse,
  output logic ack,
  output logic [2:0] ack_level,
  output logic stk_push,
  output logic [7:0] stk_data,
  output logic vec_rd,
  output logic [7:0] vec_addr,
  output logic pc_load,
  output logic [15:0] pc_value,
  output logic flags_load,
  output logic [7:0] flags_value,
  output logic busy
);
  // ----------------------------------------
  // source map
  // ----------------------------------------
  localparam logic [2:0] SRC_LVL [NSRC] = '{3'd0, 3'd0, 3'd1, 3'd2, 3'd2,
                                            3'd3, 3'd4, 3'd5, 3'd6, 3'd7};

  function automatic logic [7:0] vec_of(input logic [3:0] s);
    vec_of = VFIU_VEC_BASE + {3'b000, s, 1'b0};
  endfunction

  typedef enum logic [3:0] {
    VFIU_IDLE, VFIU_PUSH_L, VFIU_PUSH_H, VFIU_PUSH_F, VFIU_FETCH_H,
    VFIU_FETCH_L, VFIU_BRANCH, VFIU_FAST, VFIU_DONE
  } vfiu_state_e;

  vfiu_state_e state;
  logic [NSRC-1:0] pend;
  logic [NSRC-1:0] ack_clr;
  logic [7:0] lvl_req;
  logic [7:0] mode;
  logic [7:0] mask;
  logic [7:0] prio;
  logic [15:0] iptr;
  logic [7:0] flags_sh;
  logic fast_act;
  logic [3:0] cyc;
  logic [3:0] cur_src;
  logic [7:0] next_lvl_req;
  logic [7:0] prev_lvl_req;
  logic [3:0] win_src;
  logic win_ok;

  vfiu_src_pend #(.NSRC(NSRC)) u_pend (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .src_req(src_req),
    .sw_clr(sw_clr),
    .ack_clr(ack_clr),
    .pend(pend)
  );

  // ----------------------------------------
  // level requests and winner
  // ----------------------------------------
  always_comb begin
    next_lvl_req = '0;
    for (int i = 0; i < NSRC; i++) begin
      if (pend[i] && src_en[i]) begin
        next_lvl_req[SRC_LVL[i]] = 1'b1;
      end
    end
  end

  // lowest enabled level wins; lowest source in it first
  always_comb begin
    win_ok = 1'b0;
    win_src = '0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (pend[i] && src_en[i] && mask[SRC_LVL[i]]) begin
        win_ok = 1'b1;
        win_src = 4'(i);
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lvl_req <= VFIU_LVL_REQ_RST;
      prev_lvl_req <= VFIU_LVL_REQ_RST;
      irq_pulse <= 1'b0;
    end else if (clk_en) begin
      lvl_req <= next_lvl_req;
      prev_lvl_req <= lvl_req;
      irq_pulse <= |(lvl_req & ~prev_lvl_req);
    end
  end

  // ----------------------------------------
  // register file
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mask <= VFIU_MASK_RST;
      prio <= '0;
      iptr <= '0;
    end else if (clk_en) begin
      if (state == VFIU_FAST && cyc == 4'h0) begin
        iptr <= cpu_pc;
      end else if (ret_instr && fast_act) begin
        iptr <= cpu_pc;
      end else if (reg_wr) begin
        unique case (reg_addr)
          VFIU_ADDR_PTR_HI: iptr[15:8] <= reg_wdata;
          VFIU_ADDR_PTR_LO: iptr[7:0] <= reg_wdata;
          VFIU_ADDR_MASK: mask <= reg_wdata;
          VFIU_ADDR_PRIO: prio <= reg_wdata;
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode <= VFIU_MODE_RST;
    end else if (clk_en) begin
      if (state == VFIU_IDLE && instr_end && win_ok && mode[VFIU_MODE_GIE]) begin
        mode[VFIU_MODE_GIE] <= 1'b0;
      end else if (ret_instr || en_instr) begin
        mode[VFIU_MODE_GIE] <= 1'b1;
      end else if (dis_instr) begin
        mode[VFIU_MODE_GIE] <= 1'b0;
      end else if (reg_wr && reg_addr == VFIU_ADDR_MODE) begin
        mode <= reg_wdata;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= '0;
    end else if (clk_en) begin
      unique case (reg_addr)
        VFIU_ADDR_PTR_HI: reg_rdata <= iptr[15:8];
        VFIU_ADDR_PTR_LO: reg_rdata <= iptr[7:0];
        VFIU_ADDR_LVL_REQ: reg_rdata <= lvl_req;
        VFIU_ADDR_MASK: reg_rdata <= mask;
        VFIU_ADDR_MODE: reg_rdata <= mode;
        VFIU_ADDR_PRIO: reg_rdata <= prio;
        default: reg_rdata <= '0;
      endcase
    end
  end

  // ----------------------------------------
  // entry and return sequencer
  // ----------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= VFIU_IDLE;
      cyc <= '0;
      cur_src <= '0;
      fast_act <= 1'b0;
      flags_sh <= '0;
      ack <= 1'b0;
      ack_level <= '0;
      ack_clr <= '0;
      stk_push <= 1'b0;
      stk_data <= '0;
      vec_rd <= 1'b0;
      vec_addr <= '0;
      pc_load <= 1'b0;
      pc_value <= '0;
      flags_load <= 1'b0;
      flags_value <= '0;
      busy <= 1'b0;
    end else if (clk_en) begin
      ack <= 1'b0;
      ack_clr <= '0;
      stk_push <= 1'b0;
      vec_rd <= 1'b0;
      pc_load <= 1'b0;
      flags_load <= 1'b0;
      cyc <= cyc + 4'h1;
      unique case (state)
        VFIU_IDLE: begin
          cyc <= '0;
          if (ret_instr && fast_act) begin
            pc_load <= 1'b1;
            pc_value <= iptr;
            flags_load <= 1'b1;
            flags_value <= flags_sh & ~(8'h01 << VFIU_FLAG_FS);
            fast_act <= 1'b0;
          end else if (instr_end && win_ok && mode[VFIU_MODE_GIE]) begin
            ack <= 1'b1;
            ack_level <= SRC_LVL[win_src];
            ack_clr <= NSRC'(1) << win_src;
            cur_src <= win_src;
            busy <= 1'b1;
            if (mode[VFIU_MODE_FEN] && SRC_LVL[win_src] ==
                mode[VFIU_MODE_FLV_LO +: 3]) begin
              state <= VFIU_FAST;
            end else begin
              state <= VFIU_PUSH_L;
            end
          end
        end
        VFIU_PUSH_L: begin
          stk_push <= 1'b1;
          stk_data <= cpu_pc[7:0];
          state <= VFIU_PUSH_H;
        end
        VFIU_PUSH_H: begin
          stk_push <= 1'b1;
          stk_data <= cpu_pc[15:8];
          state <= VFIU_PUSH_F;
        end
        VFIU_PUSH_F: begin
          stk_push <= 1'b1;
          stk_data <= cpu_flags;
          state <= VFIU_FETCH_H;
        end
        VFIU_FETCH_H: begin
          vec_rd <= 1'b1;
          vec_addr <= vec_of(cur_src);
          state <= VFIU_FETCH_L;
        end
        VFIU_FETCH_L: begin
          vec_rd <= 1'b1;
          vec_addr <= vec_of(cur_src) + 8'h01;
          state <= VFIU_BRANCH;
        end
        VFIU_BRANCH: begin
          pc_load <= 1'b1;
          pc_value <= {vec_of(cur_src), vec_of(cur_src) + 8'h01};
          state <= VFIU_DONE;
        end
        VFIU_FAST: begin
          if (cyc == 4'h0) begin
            pc_load <= 1'b1;
            pc_value <= iptr;
            flags_sh <= cpu_flags;
            flags_load <= 1'b1;
            flags_value <= cpu_flags | (8'h01 << VFIU_FLAG_FS);
            fast_act <= 1'b1;
          end
          if (cyc == VFIU_FAST_CYC - 4'h2) begin
            state <= VFIU_DONE;
          end
        end
        VFIU_DONE: begin
          if (cyc >= VFIU_VEC_CYC - 4'h2 || fast_act) begin
            busy <= 1'b0;
            state <= VFIU_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_RST_CLR: assert property (@(posedge ref_clk)
    $fell(sys_rst) |-> lvl_req == 8'h00) else $error("level req not cleared");
  AST_ACK_GIE: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ack |-> $past(mode[VFIU_MODE_GIE]) && !mode[VFIU_MODE_GIE])
    else $error("ack without global enable");
  AST_ACK_END: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ack |-> $past(instr_end)) else $error("ack mid instruction");
  AST_PUSH3: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ack && state == VFIU_PUSH_L && clk_en |=> stk_push [*3])
    else $error("push sequence wrong");
  AST_VEC_EVEN: assert property (@(posedge ref_clk) disable iff (sys_rst)
    vec_rd && state == VFIU_FETCH_L |-> !vec_addr[0])
    else $error("odd vector");
  AST_FAST_FS: assert property (@(posedge ref_clk) disable iff (sys_rst)
    flags_load && state == VFIU_FAST |-> flags_value[VFIU_FLAG_FS])
    else $error("fast status not set");
  AST_RET_GIE: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ret_instr && clk_en && state == VFIU_IDLE && !en_instr |=> mode[VFIU_MODE_GIE])
    else $error("return did not enable");
  AST_MASK: assert property (@(posedge ref_clk) disable iff (sys_rst)
    ack |-> mask[ack_level])
    else $error("masked level served");
  COV_VEC: cover property (@(posedge ref_clk) state == VFIU_BRANCH);
  COV_FAST: cover property (@(posedge ref_clk) state == VFIU_FAST);
  COV_FRET: cover property (@(posedge ref_clk) ret_instr && fast_act);
endmodule // vfiu_top
